// ===== logic/pri_pkg.sv
// Constants for the peripheral reset and initialisation block
package pri_pkg;
  localparam logic [15:0] PRI_TOP_CFG_RST = 16'hfffb;
  localparam logic [2:0] PRI_TOP_READY_RST = 3'h3;
  localparam logic [2:0] PRI_PRIO_LOWEST = 3'h7;
  localparam logic [19:0] PRI_FETCH_ADDR = 20'hffff0;
  localparam logic [2:0] PRI_STATUS_PASSIVE = 3'h7;
  // Times in ns and derived cycle counts at 25 MHz
  localparam int PRI_CLK_PERIOD_NS = 40;
  localparam int PRI_DRIVE_NS = 40;
  localparam int PRI_DRIVE_CYC = (PRI_DRIVE_NS + PRI_CLK_PERIOD_NS - 1) / PRI_CLK_PERIOD_NS;
  localparam int PRI_GRANT_DLY_CYC = 2;
  localparam int PRI_INIT_CYC = 6;
  localparam int PRI_CNT_W = 4;
endpackage : pri_pkg

// ===== logic/pri_reset_init.sv
// Reset-time pin states and peripheral defaults for the I/O processor
`timescale 1ns/1ps
module pri_reset_init
  import pri_pkg::*;
#(
  parameter int N_MEM_SEL = 5,
  parameter int N_PERIPH_SEL = 7,
  parameter int N_DMA = 2,
  parameter int N_SRC = 8,
  parameter int N_TIMER = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hold_req,
  input wire logic [N_MEM_SEL-1:0] mem_cfg_access,
  input wire logic periph_base_cfg_access,
  input wire logic midrange_cfg_access,
  input wire logic [N_MEM_SEL-1:0] mem_sel_hit,
  input wire logic [N_PERIPH_SEL-1:0] periph_sel_hit,
  input wire logic top_region_hit,
  input wire logic [N_DMA-1:0] dma_start_req,
  input wire logic [N_DMA-1:0] dma_stop_req,
  output logic transceiver_enable_n_o,
  output logic transceiver_enable_n_oe,
  output logic read_strobe_n_o,
  output logic read_strobe_n_oe,
  output logic store_strobe_n_o,
  output logic store_strobe_n_oe,
  output logic [2:0] bus_cycle_status_o,
  output logic bus_cycle_status_oe,
  output logic bus_lock_n_o,
  output logic bus_lock_n_oe,
  output logic [15:0] muxed_addr_data_o,
  output logic muxed_addr_data_oe,
  output logic [3:0] upper_address_o,
  output logic upper_address_oe,
  output logic high_byte_enable_n_o,
  output logic high_byte_enable_n_oe,
  output logic transceiver_direction_o,
  output logic transceiver_direction_oe,
  output logic addr_latch_strobe,
  output logic bus_takeover_grant,
  output logic top_region_select_n,
  output logic [N_MEM_SEL-1:0] mem_select_n,
  output logic [N_PERIPH_SEL-1:0] periph_select_n,
  output logic [15:0] top_region_cfg,
  output logic [2:0] top_region_ready,
  output logic [N_DMA-1:0] dma_running,
  output logic [N_DMA-1:0] dma_aborted,
  output logic [N_SRC-1:0] special_nesting_bits,
  output logic [3*N_SRC-1:0] priority_level,
  output logic [N_SRC-1:0] level_sense_bits,
  output logic [N_SRC-1:0] in_service_bits,
  output logic [N_SRC-1:0] pending_bits,
  output logic [N_SRC-1:0] source_mask_bits,
  output logic [N_SRC-1:0] cascade_bits,
  output logic [7:0] priority_threshold_mask,
  output logic slave_mode,
  output logic [N_TIMER-1:0] timer_enable,
  output logic [N_TIMER-1:0] timer_compare_sel,
  output logic fetch_valid,
  output logic [19:0] fetch_addr
);

  typedef enum logic [3:0] {
    PRI_ST_DRIVE = 4'h1,
    PRI_ST_WAIT = 4'h2,
    PRI_ST_FETCH = 4'h4,
    PRI_ST_RUN = 4'h8
  } pri_state_e;

  pri_state_e state_q;
  logic [PRI_CNT_W-1:0] cnt_q;
  logic [1:0] hold_pipe_q;
  logic [N_MEM_SEL-1:0] mem_armed_q;
  logic base_seen_q;
  logic mid_seen_q;
  logic [N_DMA-1:0] dma_run_q;
  logic [N_DMA-1:0] dma_abort_q;
  logic top_cfg_loaded_q;

  // Sequencer: drive phase, internal interval, then first fetch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PRI_ST_DRIVE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        PRI_ST_DRIVE: begin
          if (cnt_q == PRI_CNT_W'(PRI_DRIVE_CYC - 1)) begin
            state_q <= PRI_ST_WAIT;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PRI_ST_WAIT: begin
          if (cnt_q == PRI_CNT_W'(PRI_INIT_CYC - 1)) begin
            state_q <= PRI_ST_FETCH;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        PRI_ST_FETCH: state_q <= PRI_ST_RUN;
        PRI_ST_RUN: state_q <= PRI_ST_RUN;
      endcase
    end
  end

  logic driving;
  assign driving = (state_q == PRI_ST_DRIVE);
  assign fetch_valid = (state_q == PRI_ST_FETCH);
  assign fetch_addr = fetch_valid ? PRI_FETCH_ADDR : 20'h00000;

  // Strobes high for one cycle, then released
  assign transceiver_enable_n_o = 1'b1;
  assign read_strobe_n_o = 1'b1;
  assign store_strobe_n_o = 1'b1;
  assign transceiver_enable_n_oe = driving;
  assign read_strobe_n_oe = driving;
  assign store_strobe_n_oe = driving;
  assign bus_cycle_status_o = PRI_STATUS_PASSIVE;
  assign bus_cycle_status_oe = driving;
  assign bus_lock_n_o = 1'b1;
  assign bus_lock_n_oe = driving;
  assign muxed_addr_data_o = 16'h0000;
  assign muxed_addr_data_oe = 1'b0;
  assign upper_address_o = 4'h0;
  assign upper_address_oe = 1'b0;
  assign high_byte_enable_n_o = 1'b1;
  assign high_byte_enable_n_oe = 1'b0;
  assign transceiver_direction_o = 1'b0;
  assign transceiver_direction_oe = 1'b0;
  // Never floated, so no enable exists for it
  assign addr_latch_strobe = 1'b0;

  // Takeover request delayed two cycles after release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_pipe_q <= 2'b00;
    end else begin
      hold_pipe_q <= {hold_pipe_q[0], hold_req};
    end
  end
  assign bus_takeover_grant = hold_pipe_q[1];

  // Select arming: memory regions live on first access, peripherals after base and midrange, top region after first clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_armed_q <= '0;
      base_seen_q <= 1'b0;
      mid_seen_q <= 1'b0;
      top_cfg_loaded_q <= 1'b0;
    end else begin
      mem_armed_q <= mem_armed_q | mem_cfg_access;
      base_seen_q <= base_seen_q | periph_base_cfg_access;
      mid_seen_q <= mid_seen_q | midrange_cfg_access;
      top_cfg_loaded_q <= 1'b1;
    end
  end

  assign top_region_cfg = PRI_TOP_CFG_RST;
  assign top_region_ready = PRI_TOP_READY_RST;
  // Selects held inactive until the drive phase ends
  assign top_region_select_n = ~(top_cfg_loaded_q & ~driving & top_region_hit);
  assign mem_select_n = ~(mem_armed_q & mem_sel_hit & {N_MEM_SEL{~driving}});
  assign periph_select_n = ~(periph_sel_hit & {N_PERIPH_SEL{base_seen_q & mid_seen_q & ~driving}});

  // DMA run flags per channel; reset stops and aborts, cycles not completed
  // Requests before the first fetch are dropped, not queued
  for (genvar ch = 0; ch < N_DMA; ch++) begin : g_dma
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        dma_run_q[ch] <= 1'b0;
        dma_abort_q[ch] <= 1'b1;
      end else if (state_q == PRI_ST_RUN) begin
        dma_run_q[ch] <= (dma_run_q[ch] | dma_start_req[ch]) & ~dma_stop_req[ch];
        dma_abort_q[ch] <= dma_abort_q[ch] & ~dma_start_req[ch];
      end
    end
  end
  assign dma_running = dma_run_q;
  assign dma_aborted = dma_abort_q;

  // Interrupt controller and timer defaults are constants here
  assign special_nesting_bits = '0;
  assign priority_level = {N_SRC{PRI_PRIO_LOWEST}};
  assign level_sense_bits = '0;
  assign in_service_bits = '0;
  assign pending_bits = '0;
  assign source_mask_bits = '1;
  assign cascade_bits = '0;
  assign priority_threshold_mask = 8'hff;
  assign slave_mode = 1'b0;
  assign timer_enable = '0;
  assign timer_compare_sel = '0;

  strobe_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(bus_cycle_status_oe == 1'b0) |-> !read_strobe_n_oe && !bus_lock_n_oe)
    else $error("strobes not floated with status");
  strobe_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    read_strobe_n_oe |=> !read_strobe_n_oe)
    else $error("strobe driven more than one cycle");
  status_passive_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus_cycle_status_oe |-> bus_cycle_status_o == PRI_STATUS_PASSIVE)
    else $error("status not passive");
  lock_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    bus_lock_n_oe |-> bus_lock_n_o)
    else $error("lock not high");
  bus_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(muxed_addr_data_oe || upper_address_oe || high_byte_enable_n_oe || transceiver_direction_oe))
    else $error("bus lines driven");
  latch_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !addr_latch_strobe)
    else $error("latch strobe not low");
  grant_delay_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hold_req ##1 1'b1 |=> bus_takeover_grant == $past(hold_req, 2))
    else $error("grant delay wrong");
  periph_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(base_seen_q && mid_seen_q) |-> &periph_select_n)
    else $error("peripheral select early");
  mem_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mem_select_n & ~mem_armed_q) == ~mem_armed_q)
    else $error("memory select before access");
  sequence fetch_seq;
    (state_q == PRI_ST_WAIT) [*6] ##1 fetch_valid;
  endsequence
  fetch_time_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(state_q == PRI_ST_WAIT) |-> fetch_seq)
    else $error("fetch interval wrong");
  fetch_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fetch_valid |-> fetch_addr == PRI_FETCH_ADDR && dma_running == '0)
    else $error("fetch address wrong");

  // Pin release steps, DMA flags and register defaults after reset
  sequence drive_end_seq;
    driving ##1 !driving;
  endsequence
  sequence hold_two_seq;
    hold_req ##1 hold_req;
  endsequence
  den_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    transceiver_enable_n_oe |=> !transceiver_enable_n_oe)
    else $error("enable strobe driven too long");
  store_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    store_strobe_n_oe |=> !store_strobe_n_oe)
    else $error("store strobe driven too long");
  strobe_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    read_strobe_n_oe |-> read_strobe_n_o && store_strobe_n_o && transceiver_enable_n_o)
    else $error("strobes not high");
  status_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !driving |-> !bus_cycle_status_oe)
    else $error("status not floated");
  lock_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    driving |-> drive_end_seq ##0 !bus_lock_n_oe)
    else $error("lock not floated");
  grant_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    driving |-> !bus_takeover_grant)
    else $error("grant high in drive phase");
  grant_rise_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hold_two_seq |=> bus_takeover_grant)
    else $error("grant did not rise");
  select_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    driving |-> top_region_select_n && &mem_select_n && &periph_select_n)
    else $error("select active in drive phase");
  top_cfg_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    top_region_cfg == PRI_TOP_CFG_RST && top_region_ready == PRI_TOP_READY_RST)
    else $error("top region config wrong");
  mem_live_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !driving |-> mem_select_n == ~(mem_armed_q & mem_sel_hit))
    else $error("armed memory select wrong");
  periph_live_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    base_seen_q && mid_seen_q && !driving |-> periph_select_n == ~periph_sel_hit)
    else $error("peripheral select not live");
  dma_stopped_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q != PRI_ST_RUN |-> dma_running == '0)
    else $error("dma running before fetch");
  dma_abort_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q != PRI_ST_RUN |-> &dma_aborted)
    else $error("dma abort flag lost");
  nest_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    special_nesting_bits == '0)
    else $error("nesting bits set");
  prio_lowest_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    priority_level == {N_SRC{PRI_PRIO_LOWEST}})
    else $error("priority not lowest");
  level_edge_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    level_sense_bits == '0)
    else $error("level sense set");
  irq_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    in_service_bits == '0 && pending_bits == '0)
    else $error("service or pending set");
  mask_all_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    &source_mask_bits)
    else $error("source not masked");
  cascade_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    cascade_bits == '0)
    else $error("cascade bit set");
  threshold_open_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    &priority_threshold_mask)
    else $error("threshold mask cleared");
  master_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !slave_mode)
    else $error("slave mode set");
  timer_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    timer_enable == '0)
    else $error("timer enabled");
  compare_max_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    timer_compare_sel == '0)
    else $error("compare choice set");
  fetch_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fetch_valid |=> !fetch_valid)
    else $error("fetch repeated");
  fetch_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !fetch_valid |-> fetch_addr == '0)
    else $error("fetch address outside fetch");
  defaults_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q != PRI_ST_RUN |-> &source_mask_bits && timer_enable == '0)
    else $error("defaults not held");

endmodule : pri_reset_init

// ===== tb/peripheral_reset_init_tb_top.sv
// Self-checking bench for the reset initialisation block
`timescale 1ns/1ps
module peripheral_reset_init_tb_top;
  import pri_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn, want, hold_req, periph_base_cfg_access, midrange_cfg_access, top_region_hit, arm_p, pb, md;
  logic transceiver_enable_n_o, transceiver_enable_n_oe, read_strobe_n_o, read_strobe_n_oe, store_strobe_n_o;
  logic store_strobe_n_oe, bus_cycle_status_oe, bus_lock_n_o, bus_lock_n_oe, muxed_addr_data_oe, upper_address_oe;
  logic high_byte_enable_n_oe, transceiver_direction_oe, addr_latch_strobe, bus_takeover_grant, top_region_select_n;
  logic slave_mode, fetch_valid;
  logic [4:0] mem_cfg_access, mem_sel_hit, mem_select_n, arm_m;
  logic [6:0] periph_sel_hit, periph_select_n;
  logic [1:0] dma_start_req, dma_stop_req, dma_running, dma_aborted;
  logic [2:0] bus_cycle_status_o, top_region_ready, timer_enable, timer_compare_sel;
  logic [15:0] top_region_cfg;
  logic [7:0] special_nesting_bits, level_sense_bits, in_service_bits, pending_bits, source_mask_bits, cascade_bits;
  logic [7:0] priority_threshold_mask;
  logic [23:0] priority_level;
  logic [19:0] fetch_addr;
  logic [31:0] r = 32'h6009b437;
  logic q[$];
  int n_fail = 0;
  int comparisons = 0;
  int i;
  pri_reset_init pri_reset_init_i (.*, .muxed_addr_data_o(), .upper_address_o(), .high_byte_enable_n_o(),
    .transceiver_direction_o());
  pri_bus_master pri_bus_master_i (.ref_clk(ref_clk), .resetn(resetn), .want(want),
    .grant(bus_takeover_grant), .hold_req(hold_req));
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [63:0] a, input logic [63:0] e);
    comparisons++;
    if (a !== e) begin
      $display("Error %0t: got %h expected %h", $time, a, e);
      n_fail++;
    end
  endtask : chk
  task automatic complete_run();
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic defaults();
    chk({top_region_cfg, top_region_ready}, {PRI_TOP_CFG_RST, PRI_TOP_READY_RST});
    chk({special_nesting_bits, level_sense_bits, in_service_bits, pending_bits, cascade_bits}, 0);
    chk({priority_level, source_mask_bits, priority_threshold_mask}, {{8{PRI_PRIO_LOWEST}}, 16'hffff});
    chk({slave_mode, timer_enable, timer_compare_sel}, 0);
  endtask : defaults
  task automatic in_reset();
    chk({transceiver_enable_n_o, transceiver_enable_n_oe, read_strobe_n_o, read_strobe_n_oe}, 4'hf);
    chk({store_strobe_n_o, store_strobe_n_oe, bus_cycle_status_o, bus_cycle_status_oe}, 6'h3f);
    chk({bus_lock_n_o, bus_lock_n_oe}, 2'h3);
    chk({muxed_addr_data_oe, upper_address_oe, high_byte_enable_n_oe, transceiver_direction_oe}, 0);
    chk({addr_latch_strobe, bus_takeover_grant}, 0);
    chk({top_region_select_n, mem_select_n, periph_select_n}, 13'h1fff);
    chk({dma_running, dma_aborted}, 4'h3);
    defaults();
  endtask : in_reset
  // Fresh random decode hits every cycle, selects judged after they settle
  task automatic step();
    @(posedge ref_clk);
    r = lfsr(r);
    want <= r[0];
    mem_sel_hit <= r[5:1];
    periph_sel_hit <= r[12:6];
    top_region_hit <= r[13];
    #1;
    chk(mem_select_n === ~(mem_sel_hit & arm_m), 1);
    chk(periph_select_n === (arm_p ? ~periph_sel_hit : 7'h7f), 1);
    chk(top_region_select_n === ~top_region_hit, 1);
  endtask : step
  task automatic pulse(input logic [4:0] m, input logic b, input logic d);
    @(posedge ref_clk);
    mem_cfg_access <= m;
    periph_base_cfg_access <= b;
    midrange_cfg_access <= d;
    @(posedge ref_clk);
    mem_cfg_access <= '0;
    periph_base_cfg_access <= 1'b0;
    midrange_cfg_access <= 1'b0;
    arm_m = arm_m | m;
    pb = pb | b;
    md = md | d;
    arm_p = pb & md;
  endtask : pulse
  // Grant notes: hold request seen at one edge is due after the next
  always @(posedge ref_clk) begin
    if (!resetn) begin
      q.delete();
    end else begin
      q.push_back(hold_req);
      #1;
      if (resetn && q.size() > 1) begin
        chk(bus_takeover_grant, q.pop_front());
      end
    end
  end
  initial begin
    {resetn, want, periph_base_cfg_access, midrange_cfg_access, top_region_hit, arm_p, pb, md} = '0;
    {mem_cfg_access, mem_sel_hit, periph_sel_hit, dma_start_req, dma_stop_req, arm_m} = '0;
    repeat (2) @(posedge ref_clk);
    in_reset();
    resetn <= 1'b1;
    dma_start_req <= 2'h3;
    @(posedge ref_clk);
    dma_start_req <= 2'h0;
    #1;
    chk({transceiver_enable_n_oe, read_strobe_n_oe, store_strobe_n_oe, bus_cycle_status_oe, bus_lock_n_oe}, 0);
    chk(addr_latch_strobe, 0);
    for (i = 1; i < 30 && fetch_valid !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 30) begin
      n_fail++;
      complete_run();
    end
    chk({i, fetch_addr}, {1 + PRI_INIT_CYC, PRI_FETCH_ADDR});
    chk(dma_running, 0);
    defaults();
    repeat (20) step();
    pulse(5'h01, 1'b1, 1'b0);
    repeat (20) step();
    pulse(5'h14, 1'b0, 1'b1);
    repeat (30) step();
    @(posedge ref_clk);
    dma_start_req <= 2'h1;
    @(posedge ref_clk);
    dma_start_req <= 2'h0;
    #1;
    chk({dma_running, dma_aborted}, 4'h6);
    @(posedge ref_clk);
    dma_start_req <= 2'h2;
    dma_stop_req <= 2'h1;
    @(posedge ref_clk);
    {dma_start_req, dma_stop_req} <= '0;
    #1;
    chk({dma_running, dma_aborted}, 4'h8);
    @(posedge ref_clk);
    resetn <= 1'b0;
    #1;
    in_reset();
    @(posedge ref_clk);
    resetn <= 1'b1;
    {arm_m, arm_p, pb, md} = '0;
    repeat (30) step();
    complete_run();
  end
endmodule : peripheral_reset_init_tb_top

// ===== tb/pri_bus_master.sv
// Far-side bus master asking for the local bus
`timescale 1ns/1ps
module pri_bus_master (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic want,
  input wire logic grant,
  output logic hold_req
);
  // Once raised, the request stays up until granted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_req <= 1'b0;
    end else if (!hold_req || grant) begin
      hold_req <= want;
    end
  end
endmodule : pri_bus_master
